//--- inc/ocq_pkg.sv
// shared constants, types and register map of the common query responder
package ocq_pkg;

   // ************************************************************
   // output queue geometry
   // ************************************************************
   localparam int QUEUE_DEPTH = 16;           // bytes held for the talker
   localparam int QUEUE_AW = 4;               // pointer width for that depth
   localparam int MSG_IDX_W = 4;              // index width inside one reply

   // ************************************************************
   // register map (byte addresses on the bus)
   // ************************************************************
   localparam logic [7:0] ADDR_OPTCFG = 8'h00; // fitted options
   localparam logic [7:0] ADDR_SRE = 8'h04;    // service request enable
   localparam logic [7:0] ADDR_STB = 8'h08;    // status byte, read only
   localparam logic [7:0] ADDR_ISTAT = 8'h0c;  // sticky events, write one to clear
   localparam logic [7:0] ADDR_IMASK = 8'h10;  // event mask
   localparam logic [7:0] ADDR_STATE = 8'h14;  // parser state, read only

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int STB_MAV = 4;                // message available
   localparam int STB_RQS = 6;                // request for service / summary
   localparam int CFG_MEM_LSB = 0;            // memory option field, two bits
   localparam int CFG_SCAN = 2;               // scanner card fitted
   localparam logic [2:0] OPTCFG_RST = 3'h0;
   localparam logic [7:0] SRE_RST = 8'h00;
   localparam int EV_OPC = 0;                 // completion reply queued
   localparam int EV_OPT = 1;                 // option reply queued
   localparam int EV_CLR = 2;                 // device clear seen
   localparam int EV_MAV = 3;                 // message became available
   localparam int NUM_EV = 4;
   localparam logic [NUM_EV-1:0] EV_RST = 4'h0;

   // ************************************************************
   // characters
   // ************************************************************
   localparam logic [7:0] CH_ONE = 8'h31;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [MSG_IDX_W-1:0] ONE_LEN = 4'h2; // digit and terminator
   localparam logic [MSG_IDX_W-1:0] CODE_LEN = 4'h4; // characters per option code

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {MEM_BASE, MEM_SMALL, MEM_LARGE} ocq_mem_t;
   typedef enum logic [2:0] {
      CMD_OPC_QUERY, CMD_OPT_QUERY, CMD_INIT_IMM, CMD_INIT_CONT_ON,
      CMD_INIT_CONT_OFF, CMD_ABORT, CMD_OTHER
   } ocq_cmd_t;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ocq_apb_req_t;

   // one parsed command from the message parser
   typedef struct packed {
      logic valid;
      ocq_cmd_t code;
   } ocq_cmd_req_t;

endpackage

//--- logic/ocq_out_queue.sv
// byte output queue between the reply sequencer and the bus talker
`timescale 1ns/1ps
module ocq_out_queue
   import ocq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic flush,
   // filling side
   input wire logic pushValid,
   input wire logic [7:0] pushData,
   output logic pushReady,
   // draining side
   output logic popValid,
   output logic [7:0] popData,
   input wire logic popReady
);

   logic [7:0] mem [QUEUE_DEPTH];   // queue storage
   logic [QUEUE_AW:0] wrPtr;        // extra bit tells full from empty
   logic [QUEUE_AW:0] rdPtr;
   logic full;
   logic empty;

   // honest flags from the pointer pair
   assign empty = (wrPtr == rdPtr);
   assign full = (wrPtr[QUEUE_AW] != rdPtr[QUEUE_AW]) &&
                 (wrPtr[QUEUE_AW-1:0] == rdPtr[QUEUE_AW-1:0]);
   assign pushReady = !full;
   assign popValid = !empty;
   assign popData = mem[rdPtr[QUEUE_AW-1:0]];

   // storage write, no reset needed for data
   always_ff @(posedge clk) begin
      if (pushValid && !full) begin
         mem[wrPtr[QUEUE_AW-1:0]] <= pushData;
      end
   end

   // write pointer
   always_ff @(posedge clk) begin
      if (sys_rst || flush) begin
         wrPtr <= '0;
      end else if (pushValid && !full) begin
         wrPtr <= wrPtr + 1'b1;
      end
   end

   // read pointer; flush drops unsent bytes
   always_ff @(posedge clk) begin
      if (sys_rst || flush) begin
         rdPtr <= '0;
      end else if (popReady && !empty) begin
         rdPtr <= rdPtr + 1'b1;
      end
   end

endmodule

//--- logic/ocq_responder.sv
// common query responder: completion and option queries, status byte, apb registers
// Overview of operation
// - completion query queues 1 after pending work
// - queued reply goes out when addressed talker
// - queued reply sets message-available bit four
// - enabled message-available sets service request bit
// - immediate initiate holds reply until idle again
// - completion query blocks later commands until queued
// - completion query under continuous initiation locks parser until device clear
// - option query queues code, sent when talking
// - option code is two comma separated fields
// - first field zero or fitted memory code
// - second field zero or scanner card code
`timescale 1ns/1ps
module ocq_responder
   import ocq_pkg::*;
#(
   // option codes, arbitrary neutral values
   parameter logic [31:0] MEM_SMALL_CODE = 32'h4f505441,
   parameter logic [31:0] MEM_LARGE_CODE = 32'h4f505442,
   parameter logic [31:0] SCAN_CODE = 32'h53434e58
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire ocq_apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parsed commands
   input wire ocq_cmd_req_t cmdReq,
   output logic cmdReady,
   // measurement engine and bus interface, same clock
   input wire logic measIdle,
   input wire logic devClear,
   input wire logic talkAddressed,
   // talker byte stream
   output logic txValid,
   output logic [7:0] txData,
   input wire logic txReady,
   // status and interrupt
   output logic [7:0] statusByte,
   output logic irq
);

   // ************************************************************
   // declarations
   // ************************************************************
   typedef enum {ST_IDLE, ST_OPC_WAIT, ST_SEND_ONE, ST_SEND_OPT} ocq_state_t;

   ocq_state_t state;                   // sequencer state
   logic [MSG_IDX_W-1:0] msgIdx;        // next byte of the reply
   logic [2:0] optCfg;                  // fitted options, software owned
   logic [7:0] sre;                     // service request enable
   logic [NUM_EV-1:0] iStat;            // sticky events
   logic [NUM_EV-1:0] iMask;            // event mask
   logic contInit;                      // continuous initiation on
   logic initPending;                   // immediate initiate not finished
   logic seenBusy;                      // engine left idle since initiate
   logic cmdTake;                       // command accepted this cycle
   logic opsDone;                       // nothing left pending
   logic qPushValid;
   logic [7:0] qPushData;
   logic qPushReady;
   logic qPopValid;
   logic qPush;                         // a reply byte enters the queue
   logic lastByte;                      // that byte ends the reply
   logic mav;                           // message available
   logic mavDly;                        // for the rising-edge event
   logic rqs;                           // service request summary
   logic [NUM_EV-1:0] evPulse;          // events this cycle
   logic wrStrobe;                      // apb write access
   logic setupPhase;                    // apb first cycle
   logic addrHit;                       // address is mapped
   logic [MSG_IDX_W-1:0] optLen;        // length of option reply

   // ************************************************************
   // helper functions
   // ************************************************************

   // byte k of a four-character code, leftmost first
   function automatic logic [7:0] code_byte(input logic [31:0] code,
                                            input logic [MSG_IDX_W-1:0] k);
      logic [7:0] b;
      b = code[31:24];
      case (k[1:0])
         2'h1: b = code[23:16];
         2'h2: b = code[15:8];
         2'h3: b = code[7:0];
         default: b = code[31:24];
      endcase
      return b;
   endfunction

   // field length: a lone zero or a full code
   function automatic logic [MSG_IDX_W-1:0] field_len(input logic present);
      return present ? CODE_LEN : 4'h1;
   endfunction

   // memory field code from the option setting
   function automatic logic [31:0] mem_code(input logic [2:0] cfg);
      logic [31:0] c;
      c = {CH_ZERO, 24'h000000};
      case (ocq_mem_t'(cfg[CFG_MEM_LSB +: 2]))
         MEM_SMALL: c = MEM_SMALL_CODE;
         MEM_LARGE: c = MEM_LARGE_CODE;
         default: c = {CH_ZERO, 24'h000000};
      endcase
      return c;
   endfunction

   // scanner field code from the option setting
   function automatic logic [31:0] scan_code(input logic [2:0] cfg);
      return cfg[CFG_SCAN] ? SCAN_CODE : {CH_ZERO, 24'h000000};
   endfunction

   // memory field counts as present only for small or large memory
   function automatic logic mem_present(input logic [2:0] cfg);
      return (cfg[CFG_MEM_LSB +: 2] == MEM_SMALL) ||
             (cfg[CFG_MEM_LSB +: 2] == MEM_LARGE);
   endfunction

   // byte idx of the option reply: field, comma, field, terminator
   function automatic logic [7:0] opt_byte(input logic [2:0] cfg,
                                           input logic [MSG_IDX_W-1:0] idx);
      logic [MSG_IDX_W-1:0] l1;
      logic [MSG_IDX_W-1:0] l2;
      logic [7:0] b;
      l1 = field_len(mem_present(cfg));
      l2 = field_len(cfg[CFG_SCAN]);
      b = CH_LF;
      if (idx < l1) begin
         b = code_byte(mem_code(cfg), idx);
      end else if (idx == l1) begin
         b = CH_COMMA;
      end else if (idx < l1 + l2 + 4'h1) begin
         b = code_byte(scan_code(cfg), idx - l1 - 4'h1);
      end
      return b;
   endfunction

   // ************************************************************
   // command acceptance
   // ************************************************************

   // only the idle sequencer takes commands, so later ones queue up
   assign cmdReady = (state == ST_IDLE);
   assign cmdTake = cmdReq.valid && cmdReady;

   // all pending work is over: no open initiate, no free-run mode
   assign opsDone = measIdle && !initPending && !contInit;

   // ************************************************************
   // measurement tracking
   // ************************************************************

   // continuous initiation mode; a clear leaves the setting alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         contInit <= 1'b0;
      end else if (cmdTake && cmdReq.code == CMD_INIT_CONT_ON) begin
         contInit <= 1'b1;
      end else if (cmdTake && cmdReq.code == CMD_INIT_CONT_OFF) begin
         contInit <= 1'b0;
      end
   end

   // initiate stays open until the engine is seen busy, then idle
   // the busy sighting guards against the engine not yet having reacted
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         initPending <= 1'b0;
         seenBusy <= 1'b0;
      end else if (cmdTake && cmdReq.code == CMD_INIT_IMM) begin
         initPending <= 1'b1;
         seenBusy <= 1'b0;
      end else if (cmdTake && cmdReq.code == CMD_ABORT) begin
         initPending <= 1'b0;
         seenBusy <= 1'b0;
      end else if (initPending) begin
         if (!measIdle) begin
            seenBusy <= 1'b1;
         end else if (seenBusy) begin
            initPending <= 1'b0;
            seenBusy <= 1'b0;
         end
      end
   end

   // ************************************************************
   // reply sequencer
   // ************************************************************

   assign optLen = field_len(mem_present(optCfg)) + field_len(optCfg[CFG_SCAN]) + 4'h2;
   assign qPushValid = (state == ST_SEND_ONE) || (state == ST_SEND_OPT);
   assign qPushData = (state == ST_SEND_ONE) ?
                      ((msgIdx == '0) ? CH_ONE : CH_LF) :
                      opt_byte(optCfg, msgIdx);
   assign qPush = qPushValid && qPushReady;
   assign lastByte = (state == ST_SEND_ONE) ? (msgIdx == ONE_LEN - 4'h1) :
                     (msgIdx == optLen - 4'h1);

   // the send states advance only on accepted bytes, so a full queue stalls here
   always_ff @(posedge clk) begin
      if (sys_rst || devClear) begin
         state <= ST_IDLE;
         msgIdx <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               msgIdx <= '0;
               if (cmdTake && cmdReq.code == CMD_OPC_QUERY) begin
                  state <= ST_OPC_WAIT;
               end else if (cmdTake && cmdReq.code == CMD_OPT_QUERY) begin
                  state <= ST_SEND_OPT;
               end
            end
            ST_OPC_WAIT: begin
               // with free-running initiation this never leaves
               if (opsDone) begin
                  state <= ST_SEND_ONE;
               end
            end
            ST_SEND_ONE, ST_SEND_OPT: begin
               if (qPush && lastByte) begin
                  state <= ST_IDLE;
                  msgIdx <= '0;
               end else if (qPush) begin
                  msgIdx <= msgIdx + 4'h1;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // output queue and talker
   // ************************************************************

   // a clear empties the queue as well as the parser
   ocq_out_queue u_queue (
      .clk(clk),
      .sys_rst(sys_rst),
      .flush(devClear),
      .pushValid(qPushValid),
      .pushData(qPushData),
      .pushReady(qPushReady),
      .popValid(qPopValid),
      .popData(txData),
      .popReady(txReady && talkAddressed)
   );

   // bytes leave only while addressed to talk
   assign txValid = qPopValid && talkAddressed;

   // ************************************************************
   // status byte
   // ************************************************************

   assign mav = qPopValid;
   assign rqs = mav && sre[STB_MAV];

   // registered copy for the outside world
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         statusByte <= 8'h00;
         mavDly <= 1'b0;
      end else begin
         statusByte <= 8'h00;
         statusByte[STB_MAV] <= mav;
         statusByte[STB_RQS] <= rqs;
         mavDly <= mav;
      end
   end

   // ************************************************************
   // events and interrupt
   // ************************************************************

   always_comb begin
      evPulse = '0;
      evPulse[EV_OPC] = qPush && lastByte && (state == ST_SEND_ONE);
      evPulse[EV_OPT] = qPush && lastByte && (state == ST_SEND_OPT);
      evPulse[EV_CLR] = devClear;
      evPulse[EV_MAV] = mav && !mavDly;
   end

   // sticky bits; a new event beats a same-cycle clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         iStat <= EV_RST;
      end else if (wrStrobe && apbReq.paddr == ADDR_ISTAT) begin
         iStat <= (iStat & ~apbReq.pwdata[NUM_EV-1:0]) | evPulse;
      end else begin
         iStat <= iStat | evPulse;
      end
   end

   assign irq = |(iStat & iMask);

   // ************************************************************
   // apb slave
   // ************************************************************

   // zero wait states: every access completes in its access cycle
   assign pready = 1'b1;
   assign setupPhase = apbReq.psel && !apbReq.penable;
   assign wrStrobe = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign addrHit = (apbReq.paddr == ADDR_OPTCFG) || (apbReq.paddr == ADDR_SRE) ||
                    (apbReq.paddr == ADDR_STB) || (apbReq.paddr == ADDR_ISTAT) ||
                    (apbReq.paddr == ADDR_IMASK) || (apbReq.paddr == ADDR_STATE);
   assign pslverr = apbReq.psel && apbReq.penable && !addrHit;

   // writable registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         optCfg <= OPTCFG_RST;
         sre <= SRE_RST;
         iMask <= EV_RST;
      end else if (wrStrobe) begin
         if (apbReq.paddr == ADDR_OPTCFG) begin
            optCfg <= apbReq.pwdata[2:0];
         end
         if (apbReq.paddr == ADDR_SRE) begin
            // the summary bit itself cannot be enabled
            sre <= apbReq.pwdata[7:0] & ~(8'h01 << STB_RQS);
         end
         if (apbReq.paddr == ADDR_IMASK) begin
            iMask <= apbReq.pwdata[NUM_EV-1:0];
         end
      end
   end

   // read data captured in the setup cycle, stable through the access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (setupPhase) begin
         prdata <= 32'h00000000;
         unique case (apbReq.paddr)
            ADDR_OPTCFG: prdata[2:0] <= optCfg;
            ADDR_SRE: prdata[7:0] <= sre;
            ADDR_STB: prdata[7:0] <= statusByte;
            ADDR_ISTAT: prdata[NUM_EV-1:0] <= iStat;
            ADDR_IMASK: prdata[NUM_EV-1:0] <= iMask;
            ADDR_STATE: prdata[3:0] <= {contInit, initPending,
                                        state == ST_OPC_WAIT, cmdReady};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

//--- verification/ocq_ctl_model.sv
// controller side model: sends parsed commands, clears, listens as talker
`timescale 1ns/1ps
module ocq_ctl_model
   import ocq_pkg::*;
(
   // clock
   input wire logic clk,
   // commands and clear
   output ocq_cmd_req_t cmdReq,
   input wire logic cmdReady,
   output logic devClear,
   // talker bytes
   output logic talkAddressed,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   // stall the listener when high
   input wire logic slow
);
   logic [7:0] rxQ[$]; // bytes heard so far
   logic [3:0] pace = 4'h1; // stall pattern
   initial begin
      cmdReq = '0;
      devClear = 1'b0;
      talkAddressed = 1'b0;
   end
   // listener: one byte per handshake, random stalls when slow
   always @(posedge clk) begin
      if (txValid && txReady) rxQ.push_back(txData);
      pace <= {pace[2:0], pace[3] ^ pace[2]};
      txReady <= !slow || pace[0];
   end
   // hold the command until the parser takes it
   task automatic issue(input ocq_cmd_t c, output bit ok);
      int n;
      begin
         n = 0;
         @(posedge clk);
         cmdReq <= '{1'b1, c};
         @(posedge clk);
         while (!cmdReady && n < 2000) begin
            n++;
            @(posedge clk);
         end
         ok = cmdReady;
         cmdReq <= '0;
      end
   endtask
   // one-cycle clear, the only way out of a locked query
   task automatic clear();
      begin
         @(posedge clk);
         devClear <= 1'b1;
         @(posedge clk);
         devClear <= 1'b0;
      end
   endtask
   // talk until n bytes arrived or the bound runs out
   task automatic listen(input int n, output bit ok);
      int k;
      begin
         k = 0;
         @(posedge clk);
         talkAddressed <= 1'b1;
         while (rxQ.size() < n && k < 1000) begin
            k++;
            @(posedge clk);
         end
         ok = rxQ.size() >= n;
         talkAddressed <= 1'b0;
      end
   endtask
endmodule

//--- verification/ocq_responder_chk.sv
// checker of the common query responder ports
`timescale 1ns/1ps
module ocq_responder_chk
   import ocq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire ocq_apb_req_t apbReq,
   input wire logic pslverr,
   input wire ocq_cmd_req_t cmdReq,
   input wire logic cmdReady,
   input wire logic measIdle,
   input wire logic devClear,
   input wire logic talkAddressed,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txReady,
   input wire logic [7:0] statusByte
);
   // *****
   // helper state
   // *****
   logic taken; // command accepted at this edge
   logic opcWait; // completion query outstanding
   logic contOn; // continuous initiation on
   assign taken = cmdReq.valid && cmdReady;
   // outstanding query, dropped on finish or clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opcWait <= 1'b0;
      end else if (taken && cmdReq.code == CMD_OPC_QUERY) begin
         opcWait <= 1'b1;
      end else if (cmdReady || devClear) begin
         opcWait <= 1'b0;
      end
   end
   // continuous initiation as last commanded; a clear keeps it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         contOn <= 1'b0;
      end else if (taken && cmdReq.code == CMD_INIT_CONT_ON) begin
         contOn <= 1'b1;
      end else if (taken && cmdReq.code == CMD_INIT_CONT_OFF) begin
         contOn <= 1'b0;
      end
   end
   // *****
   // properties
   // *****
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // idle seen three edges before the parser frees up
   a_opc_idle:
      assert property ($rose(cmdReady) && opcWait |-> $past(measIdle, 3))
      else $error("completion reply while engine busy");
   a_query_block:
      assert property (taken && cmdReq.code inside {CMD_OPC_QUERY, CMD_OPT_QUERY}
         && !devClear |=> !cmdReady) else $error("query did not hold the parser");
   a_lock_cont:
      assert property (opcWait && contOn && !devClear |=> !cmdReady)
      else $error("locked query released without clear");
   a_clear_frees:
      assert property (devClear && !cmdReq.valid |=> cmdReady && !txValid)
      else $error("clear left parser blocked");
   a_talk_gate:
      assert property (!talkAddressed |-> !txValid) else $error("byte offered while not talker");
   a_mav_set:
      assert property (txValid |=> statusByte[STB_MAV]) else $error("message bit missing");
   a_rqs_mav:
      assert property (statusByte[STB_RQS] |-> statusByte[STB_MAV]) else $error("summary alone");
   a_err_access:
      assert property (pslverr |-> apbReq.psel && apbReq.penable) else $error("error off access");
   c_opc_done: cover property ($rose(cmdReady) && opcWait);
   c_clear_lock: cover property (opcWait && contOn ##1 devClear);
   c_comma_out: cover property (txValid && txReady && txData == CH_COMMA);
endmodule

bind ocq_responder ocq_responder_chk u_chk (.clk, .sys_rst, .apbReq, .pslverr, .cmdReq,
   .cmdReady, .measIdle, .devClear, .talkAddressed, .txValid, .txData, .txReady, .statusByte);

//--- verification/testbench.sv
// self-checking bench of the common query responder
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
   import ocq_pkg::*;
;
   // option codes, arbitrary values
   localparam logic [31:0] SMALL_CODE = 32'h4d4f5031;
   localparam logic [31:0] LARGE_CODE = 32'h4d4f5032;
   localparam logic [31:0] SCAN_ID = 32'h53434e31;
   logic clk, sys_rst, pready, pslverr, cmdReady, measIdle, devClear, talkAddressed;
   logic txValid, txReady, irq, slow;
   logic [31:0] prdata;
   logic [7:0] txData, statusByte;
   ocq_apb_req_t apbReq;
   ocq_cmd_req_t cmdReq;
   logic [31:0] rnd; // lfsr state
   logic [2:0] cfg; // option set under test
   int error_cnt, samples_checked;
   logic [7:0] expQ[$]; // reference reply bytes
   ocq_responder #(.MEM_SMALL_CODE(SMALL_CODE), .MEM_LARGE_CODE(LARGE_CODE),
      .SCAN_CODE(SCAN_ID)) u_dut (.clk, .sys_rst, .apbReq, .prdata, .pready, .pslverr,
      .cmdReq, .cmdReady, .measIdle, .devClear, .talkAddressed, .txValid, .txData,
      .txReady, .statusByte, .irq);
   ocq_ctl_model u_ctl (.clk, .cmdReq, .cmdReady, .devClear, .talkAddressed, .txValid,
      .txData, .txReady, .slow);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // one apb transfer, request held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      begin
         n = 0;
         @(posedge clk);
         apbReq <= '{1'b1, 1'b0, w, a, d};
         @(posedge clk);
         apbReq.penable <= 1'b1;
         @(posedge clk);
         while (!pready && n < 50) begin
            n++;
            @(posedge clk);
         end
         check_ok(pready);
         q = prdata;
         e = pslverr;
         apbReq <= '0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      begin
         apb(1'b0, a, 32'h0, q, e);
         `CHK(q, x)
         `CHK(e, xe)
      end
   endtask
   // a used-up bound is a mismatch and ends the run
   task automatic check_ok(input bit ok);
      if (!ok) begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic issue(input ocq_cmd_t c);
      bit ok;
      begin
         u_ctl.issue(c, ok);
         check_ok(ok);
      end
   endtask
   task automatic push_code(input logic [31:0] c);
      for (int i = 3; i >= 0; i--) expQ.push_back(c[8*i +: 8]);
   endtask
   // reference option reply; code 3 reads as base memory
   task automatic exp_opt(input logic [2:0] c);
      begin
         if (c[1:0] == 2'h1) push_code(SMALL_CODE);
         else if (c[1:0] == 2'h2) push_code(LARGE_CODE);
         else expQ.push_back(CH_ZERO);
         expQ.push_back(CH_COMMA);
         if (c[2]) push_code(SCAN_ID);
         else expQ.push_back(CH_ZERO);
         expQ.push_back(CH_LF);
      end
   endtask
   // talk, then compare every byte heard with the reference
   task automatic drain();
      bit ok;
      logic [7:0] g, x;
      begin
         u_ctl.listen(expQ.size(), ok);
         check_ok(ok);
         while (expQ.size() > 0) begin
            g = u_ctl.rxQ.pop_front();
            x = expQ.pop_front();
            `CHK(g, x)
         end
      end
   endtask
   task automatic final_report();
      begin
         if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   // *****
   // main sequence
   // *****
   initial begin
      sys_rst = 1'b1;
      apbReq = '0;
      measIdle = 1'b1;
      slow = 1'b0;
      rnd = 32'h3814;
      error_cnt = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, then an unmapped slot
      for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, 1'b0);
      rd_chk(ADDR_STATE, 32'h1, 1'b0);
      rd_chk(8'h18, 32'h0, 1'b1);
      // every option set, then one random, listener stalling at random
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         cfg = (i < 8) ? 3'(i) : rnd[2:0];
         slow <= rnd[3];
         wr(ADDR_OPTCFG, {29'h0, cfg});
         issue(CMD_OPT_QUERY);
         exp_opt(cfg);
         drain();
      end
      rd_chk(ADDR_ISTAT, 32'ha, 1'b0);
      wr(ADDR_ISTAT, 32'hf);
      // completion query behind an immediate initiate
      wr(ADDR_SRE, 32'h10);
      wr(ADDR_IMASK, 32'h9);
      issue(CMD_INIT_CONT_OFF);
      issue(CMD_ABORT);
      issue(CMD_INIT_IMM);
      measIdle <= 1'b0;
      issue(CMD_OPC_QUERY);
      rnd = lfsr(rnd);
      repeat (8 + rnd[4:0]) @(negedge clk);
      `CHK(cmdReady, 1'b0)
      `CHK(statusByte, 8'h00)
      @(posedge clk) measIdle <= 1'b1;
      for (int n = 0; n < 500 && !cmdReady; n++) @(negedge clk);
      check_ok(cmdReady);
      `CHK(statusByte, 8'h50)
      `CHK(irq, 1'b1)
      rd_chk(ADDR_ISTAT, 32'h9, 1'b0);
      wr(ADDR_IMASK, 32'h0);
      @(negedge clk);
      `CHK(irq, 1'b0)
      expQ = '{CH_ONE, CH_LF};
      drain();
      repeat (2) @(negedge clk);
      `CHK(statusByte, 8'h00)
      // continuous initiation locks the query until a clear
      wr(ADDR_ISTAT, 32'hf);
      issue(CMD_INIT_CONT_ON);
      issue(CMD_OPC_QUERY);
      repeat (40) @(negedge clk);
      `CHK(cmdReady, 1'b0)
      u_ctl.clear();
      @(negedge clk);
      `CHK(cmdReady, 1'b1)
      rd_chk(ADDR_ISTAT, 32'h4, 1'b0);
      issue(CMD_INIT_CONT_OFF);
      issue(CMD_OPC_QUERY);
      expQ = '{CH_ONE, CH_LF};
      drain();
      final_report();
   end
endmodule
